/* File: include/uart_rx_brk_map.vh */
// Offsets, fields, reset values and timing counts of the serial receiver and break block
`ifndef UART_RX_BRK_MAP_VH
`define UART_RX_BRK_MAP_VH
`define ADDR_CTRL       3'h0
`define ADDR_STATUS     3'h1
`define ADDR_DATA       3'h2
`define ADDR_DIVISOR    3'h3
`define CTRL_RX_EN      0
`define CTRL_NINTH      1
`define CTRL_PAR_ON     2
`define CTRL_PAR_ODD    3
`define CTRL_TWO_STOP   4
`define CTRL_BREAK      5
`define CTRL_RX_IE      6
`define CTRL_RESET      8'h00
`define ST_AVAIL        0
`define ST_OVERRUN      1
`define ST_FRAME        2
`define ST_NOISE        3
`define ST_PARITY       4
`define ST_IDLE         5
`define ST_NINTH        6
`define ST_TX_IDLE      7
`define DIVISOR_RESET   8'h00
`define OVERSAMPLE      5'd16
`define BREAK_BITS      4'd13
`endif

/* File: verilog/uart_rx_brk.v */
// Serial receiver with two-word FIFO, error flags and break transmitter
`timescale 1ns/1ps
`include "uart_rx_brk_map.vh"

// Operation
// - Break-send held over divisor+1 clocks makes the next transmission a break.
// - A break is a start bit, 13 zero bits times N, then stop bits.
// - Sending a break raises no transmit interrupt request.
// - Break-send held high keeps break characters going back to back.
// - After break-send clears, finish current break then send one or two stops.
// - Ninth-bit select gives 9-bit words with top bit in the ninth-bit field.
// - Line sampled at sixteen times baud; shift register shifts once per bit.
// - Each bit level is a majority vote of three samples.
// - After the stop bit sample the word moves to the buffer if room.
// - Data assembled least significant bit first.
// - Two-entry FIFO; a third word completing while full is dropped, overrun set.
// - Setting receive enable starts the hunt for a start bit.
// - Receive-available flag is set while the FIFO holds a word.
// - With interrupt enable, request on word transfer and on overrun.
// - Available flag clears only after status read then data read, or when receive enable clears.
// - Framing, noise, parity and overrun flags set on their conditions.
// - Break ends after word plus one stop: zeros stored, framing and available set.
// - After a break wait for a high line before hunting a new start.
// - Idle flag low from start detect to stop, high otherwise.
// - On a break the idle flag rises before the line returns high.
// - Available flag is set by an internal event, not the line level.
// - Only one stop bit is checked by the receiver.
// - Overrun keeps FIFO words; only the shift register is overwritten.
module uart_rx_brk (
  // Clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // Register port
  input  wire [2:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_en,
  input  wire       rd_en,
  output reg  [7:0] rd_data,
  // Serial line
  input  wire       rx_line,
  output reg        tx_line,
  // Interrupt request
  output reg        rx_irq
);

  // Receiver walk: hunt for a falling edge, check the start bit at mid bit,
  // shift data and optional parity, then sample one stop bit at mid bit.
  // A low stop sample marks a framing error; the receiver then parks in a
  // wait state until the line is high again, so a long break is never
  // taken for the start of the next frame.
  localparam RX_HUNT  = 2'd0;
  localparam RX_DATA  = 2'd1;
  localparam RX_STOP  = 2'd2;
  localparam RX_WAIT  = 2'd3;

  // Transmit side only ever carries break characters here; normal data
  // transmission lives elsewhere, so the line idles high otherwise.
  localparam TX_IDLE  = 2'd0;
  localparam TX_START = 2'd1;
  localparam TX_ZERO  = 2'd2;
  localparam TX_STOP  = 2'd3;

  reg  [7:0] ctrl;
  reg  [7:0] baud_divisor;
  reg  [2:0] line_sync;
  reg        line;
  reg        line_prev;
  reg  [7:0] div_cnt;
  wire       tick;
  reg  [1:0] rx_state;
  reg  [3:0] os_cnt;
  reg  [3:0] bit_cnt;
  reg  [8:0] rx_shift_reg;
  reg  [2:0] votes;
  reg        noisy;
  reg        par_acc;
  reg  [8:0] fifo_mem [0:1];
  reg  [2:0] fifo_flags [0:1];
  reg        rd_ptr;
  reg        wr_ptr;
  reg  [1:0] fifo_cnt;
  reg        overrun_flag;
  reg        rx_idle_flag;
  reg        status_seen;
  reg  [1:0] tx_state;
  reg  [8:0] brk_hold;
  reg        brk_armed;
  reg  [3:0] tx_bit;
  reg  [3:0] tx_os;
  reg        tx_stop2;
  wire       ninth_bit_select;
  wire       parity_on_bit;
  wire       break_send_ctrl;
  wire [3:0] word_bits;
  wire       vote;
  wire       push;
  wire       pop;
  wire       rx_avail_flag;
  wire       tx_tick;

  assign ninth_bit_select = ctrl[`CTRL_NINTH];
  assign parity_on_bit    = ctrl[`CTRL_PAR_ON];
  assign break_send_ctrl  = ctrl[`CTRL_BREAK];
  assign word_bits = ninth_bit_select ? 4'd9 : 4'd8;
  assign rx_avail_flag = (fifo_cnt != 2'd0);
  assign tick = (div_cnt == 8'h00);

  // Majority of three, used for the start check and every data bit
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  assign vote = maj3({votes[1:0], line});

  // Register writes
  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl         <= `CTRL_RESET;
      baud_divisor <= `DIVISOR_RESET;
    end else if (wr_en) begin
      if (addr == `ADDR_CTRL)
        ctrl <= wr_data;
      if (addr == `ADDR_DIVISOR)
        baud_divisor <= wr_data;
    end
  end

  // Three-stage input synchroniser; a change counts when stages two and three agree
  always @(posedge clock) begin
    if (sys_rst) begin
      line_sync <= 3'h7;
      line      <= 1'b1;
      line_prev <= 1'b1;
    end else begin
      line_sync <= {line_sync[1:0], rx_line};
      if (line_sync[1] == line_sync[2])
        line <= line_sync[2];
      line_prev <= line;
    end
  end

  // Sixteen-times baud tick, shared by receive and transmit
  always @(posedge clock) begin
    if (sys_rst)
      div_cnt <= 8'h00;
    else if (tick)
      div_cnt <= baud_divisor;
    else
      div_cnt <= div_cnt - 8'h01;
  end

  // A pop in the same cycle frees the head slot, so a full FIFO still takes
  // the word; otherwise the word would vanish with no overrun indication.
  assign push = (rx_state == RX_STOP) && tick && (os_cnt == 4'd8) &&
                ((fifo_cnt != 2'd2) || pop);

  // Receiver state machine
  always @(posedge clock) begin
    if (sys_rst || !ctrl[`CTRL_RX_EN]) begin
      rx_state     <= RX_HUNT;
      os_cnt       <= 4'h0;
      bit_cnt      <= 4'h0;
      rx_shift_reg <= 9'h000;
      votes        <= 3'h7;
      noisy        <= 1'b0;
      par_acc      <= 1'b0;
      rx_idle_flag <= 1'b1;
    end else begin
      if (tick)
        votes <= {votes[1:0], line};
      case (rx_state)
        RX_HUNT: begin
          os_cnt <= 4'h0;
          if (line_prev && !line) begin
            rx_state     <= RX_DATA;
            bit_cnt      <= 4'hf;
            noisy        <= 1'b0;
            par_acc      <= ctrl[`CTRL_PAR_ODD];
            rx_idle_flag <= 1'b0;
          end
        end
        RX_DATA: if (tick) begin
          os_cnt <= os_cnt + 4'h1;
          if (os_cnt == 4'd8) begin
            if (votes[1:0] != {line, line})
              noisy <= 1'b1;
            if (bit_cnt == 4'hf) begin
              if (vote)
                rx_state <= RX_HUNT;
              if (vote)
                rx_idle_flag <= 1'b1;
              bit_cnt <= 4'h0;
            end else begin
              rx_shift_reg <= ninth_bit_select ? {vote, rx_shift_reg[8:1]}
                                               : {1'b0, vote, rx_shift_reg[7:1]};
              par_acc <= par_acc ^ vote;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == word_bits - 4'h1 + {3'h0, parity_on_bit})
                rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: if (tick) begin
          os_cnt <= os_cnt + 4'h1;
          if (os_cnt == 4'd8) begin
            rx_idle_flag <= 1'b1;
            rx_state <= vote ? RX_HUNT : RX_WAIT;
          end
        end
        RX_WAIT: if (line)
          rx_state <= RX_HUNT;
        default: rx_state <= RX_HUNT;
      endcase
    end
  end

  // The parity bit, when on, was shifted in last; this drops the lowest stored bit and leaves parity in the data field
  wire [8:0] rx_word = parity_on_bit ?
      (ninth_bit_select ? {1'b0, rx_shift_reg[8:1]} : {1'b0, 1'b0, rx_shift_reg[7:1]})
    : rx_shift_reg;
  wire       frame_bad = !vote;
  wire       par_bad   = parity_on_bit & par_acc;
  wire       stop_done = (rx_state == RX_STOP) && tick && (os_cnt == 4'd8);

  assign pop = rd_en && (addr == `ADDR_DATA) && status_seen && rx_avail_flag;

  // Two-entry receive FIFO with per-word error flags.
  // Pointers are single bits; when full they are equal, and the slot under
  // the read pointer is the one that a simultaneous push overwrites after
  // its word has been handed out.
  // Error flags travel with their word, so the status read always shows
  // the flags of the word that the next data read returns.
  // Overrun keeps both stored words and drops only the incoming one.
  always @(posedge clock) begin
    if (sys_rst || !ctrl[`CTRL_RX_EN]) begin
      rd_ptr       <= 1'b0;
      wr_ptr       <= 1'b0;
      fifo_cnt     <= 2'd0;
      overrun_flag <= 1'b0;
      fifo_mem[0]  <= 9'h000;
      fifo_mem[1]  <= 9'h000;
      fifo_flags[0] <= 3'h0;
      fifo_flags[1] <= 3'h0;
    end else begin
      if (push) begin
        fifo_mem[wr_ptr]   <= frame_bad ? 9'h000 : rx_word;
        fifo_flags[wr_ptr] <= {par_bad, noisy, frame_bad};
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, pop};
      if (stop_done && (fifo_cnt == 2'd2) && !pop)
        overrun_flag <= 1'b1;
      else if (pop)
        overrun_flag <= 1'b0;
    end
  end

  // Status-then-data clear sequence.
  // Any other read between the two breaks the sequence, so a stray
  // register poll cannot lose a word by accident.
  always @(posedge clock) begin
    if (sys_rst)
      status_seen <= 1'b0;
    else if (rd_en && addr == `ADDR_STATUS)
      status_seen <= 1'b1;
    else if (rd_en)
      status_seen <= 1'b0;
  end

  always @(posedge clock) begin
    if (sys_rst)
      rx_irq <= 1'b0;
    else
      rx_irq <= ctrl[`CTRL_RX_IE] &
                (push | (stop_done & (fifo_cnt == 2'd2) & !pop));
  end

  // Register reads, data valid one cycle after the strobe
  always @(posedge clock) begin
    if (sys_rst)
      rd_data <= 8'h00;
    else if (rd_en) begin
      case (addr)
        `ADDR_CTRL:    rd_data <= ctrl;
        `ADDR_DIVISOR: rd_data <= baud_divisor;
        `ADDR_DATA:    rd_data <= fifo_mem[rd_ptr][7:0];
        `ADDR_STATUS: begin
          rd_data <= 8'h00;
          rd_data[`ST_AVAIL]   <= rx_avail_flag;
          rd_data[`ST_OVERRUN] <= overrun_flag;
          rd_data[`ST_FRAME]   <= rx_avail_flag & fifo_flags[rd_ptr][0];
          rd_data[`ST_NOISE]   <= rx_avail_flag & fifo_flags[rd_ptr][1];
          rd_data[`ST_PARITY]  <= rx_avail_flag & fifo_flags[rd_ptr][2];
          rd_data[`ST_IDLE]    <= rx_idle_flag;
          rd_data[`ST_NINTH]   <= fifo_mem[rd_ptr][8];
          rd_data[`ST_TX_IDLE] <= (tx_state == TX_IDLE);
        end
        default:       rd_data <= 8'h00;
      endcase
    end
  end

  // Break arms only after the control has held high beyond divisor+1 clocks.
  // The hold counter stops once armed, so a long hold cannot wrap it.
  // Limitation: the armed break starts on the next bit boundary of the
  // shared tick, not on the exact clock the control was set.
  always @(posedge clock) begin
    if (sys_rst || !break_send_ctrl) begin
      brk_hold  <= 9'h000;
      brk_armed <= 1'b0;
    end else if (brk_hold > {1'b0, baud_divisor} + 9'h001) begin
      brk_armed <= 1'b1;
    end else begin
      brk_hold <= brk_hold + 9'h001;
    end
  end

  assign tx_tick = tick && (tx_os == 4'hf);

  // Break transmitter; no transmit interrupt path exists for it.
  // Zeros run in groups of thirteen bit times; the control is checked
  // only at a group boundary, so a cleared control still finishes the
  // character in progress before the stop bits go out.
  always @(posedge clock) begin
    if (sys_rst) begin
      tx_state <= TX_IDLE;
      tx_line  <= 1'b1;
      tx_bit   <= 4'h0;
      tx_os    <= 4'h0;
      tx_stop2 <= 1'b0;
    end else begin
      if (tick)
        tx_os <= tx_os + 4'h1;
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1;
          if (brk_armed && tx_tick) begin
            tx_state <= TX_START;
            tx_line  <= 1'b0;
          end
        end
        TX_START: if (tx_tick) begin
          tx_state <= TX_ZERO;
          tx_bit   <= 4'h0;
        end
        TX_ZERO: if (tx_tick) begin
          if (tx_bit == `BREAK_BITS - 4'h1) begin
            tx_bit <= 4'h0;
            if (!break_send_ctrl) begin
              tx_state <= TX_STOP;
              tx_line  <= 1'b1;
              tx_stop2 <= ctrl[`CTRL_TWO_STOP];
            end
          end else begin
            tx_bit <= tx_bit + 4'h1;
          end
        end
        TX_STOP: if (tx_tick) begin
          if (tx_stop2)
            tx_stop2 <= 1'b0;
          else
            tx_state <= TX_IDLE;
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

endmodule // uart_rx_brk

/* File: tb/uart_rx_brk_properties.sv */
// Port checker for the serial receiver and break block
`timescale 1ns/1ps
module uart_rx_brk_properties (
  // Clock and reset
  input wire       clock,
  input wire       sys_rst,
  // Register port
  input wire [2:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rd_data,
  // Serial and interrupt
  input wire       rx_line,
  input wire       tx_line,
  input wire       rx_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic brk_q, ie_q, en_q;
  // Shadow of the control register
  always @(posedge clock) begin
    if (sys_rst) begin
      {brk_q, ie_q, en_q} <= 3'b000;
    end else if (wr_en && addr == 3'h0) begin
      {brk_q, ie_q, en_q} <= {wr_data[5], wr_data[6], wr_data[0]};
    end
  end
  sequence s_low_run; !tx_line [*8]; endsequence
  property p_tx_rst; $past(sys_rst) |-> tx_line; endproperty
  property p_brk_min; $fell(tx_line) |=> s_low_run; endproperty
  property p_brk_req; $fell(tx_line) |-> brk_q; endproperty
  property p_brk_hold; $rose(tx_line) |-> !brk_q; endproperty
  property p_irq_pulse; rx_irq |=> !rx_irq; endproperty
  property p_irq_ie; rx_irq |-> ie_q; endproperty
  property p_irq_en; rx_irq |-> en_q; endproperty
  property p_rd_hold; !rd_en |=> $stable(rd_data); endproperty
  property p_unmapped; rd_en && addr[2] |=> rd_data == 8'h00; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("tx line low after reset");
  a_brk_min: assert property (p_brk_min) else $error("break too short");
  a_brk_req: assert property (p_brk_req) else $error("tx low without break");
  a_brk_hold: assert property (p_brk_hold) else $error("break cut short");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq not a pulse");
  a_irq_ie: assert property (p_irq_ie) else $error("irq while masked");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // uart_rx_brk_properties
bind uart_rx_brk uart_rx_brk_properties chk (.clock(clock), .sys_rst(sys_rst), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_line(rx_line),
  .tx_line(tx_line), .rx_irq(rx_irq));

/* File: tb/uart_remote.sv */
// Remote serial transmitter, 16 clocks per bit with divisor 0
`timescale 1ns/1ps
module uart_remote (
  // Clock
  input  wire  clock,
  // Line
  output logic line
);
  initial line = 1'b1;
  task bit_out(input logic b);
    @(posedge clock) line <= b;
    repeat (15) @(posedge clock);
  endtask
  // Start, data LSB first, one stop
  task send(input logic [8:0] v, input int n);
    bit_out(1'b0);
    for (int i = 0; i < n; i++) bit_out(v[i]);
    bit_out(1'b1);
  endtask
  task low(input int bits);
    repeat (bits) bit_out(1'b0);
    bit_out(1'b1);
  endtask
endmodule // uart_remote

/* File: tb/uart_rx_brk_bench.sv */
// Self-checking bench for the serial receiver and break block
`timescale 1ns/1ps
module uart_rx_brk_bench;
  logic       clock = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wr_data = 8'h00, rd_data, v;
  wire        rx_line, tx_line, rx_irq;
  int         fail_count = 0, total_checks = 0, n;
  always #5 clock = ~clock;
  uart_rx_brk DUT (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_line(rx_line),
    .tx_line(tx_line), .rx_irq(rx_irq));
  uart_remote remote (.clock(clock), .line(rx_line));
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock) {addr, wr_data, wr_en} <= {a, d, 1'b1};
    @(posedge clock) wr_en <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock) {addr, rd_en} <= {a, 1'b1};
    @(posedge clock) rd_en <= 1'b0;
    #1 d = rd_data;
  endtask
  task setup(input logic [7:0] c);
    wr(3'h0, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h0, c);
  endtask
  task t_regs;
    rd(3'h0, v); chk("ctrl", 8'h00, v);
    rd(3'h1, v); chk("status", 8'ha0, v);
    rd(3'h5, v); chk("unmapped", 8'h00, v);
    $display("test regs done");
  endtask
  task t_rx8;
    setup(8'h41);
    fork remote.send(9'h0a5, 8); join_none
    n = 0;
    while (rx_irq !== 1'b1 && n < 400) begin @(posedge clock); n++; end
    chk("irq", 8'h01, {7'h0, rx_irq});
    repeat (30) @(posedge clock);
    rd(3'h2, v); chk("data", 8'ha5, v);
    rd(3'h1, v); chk("status", 8'ha1, v);
    rd(3'h2, v); chk("data", 8'ha5, v);
    rd(3'h1, v); chk("status", 8'ha0, v);
    $display("test rx8 done");
  endtask
  task t_ninth;
    setup(8'h43);
    remote.send(9'h13c, 9);
    repeat (10) @(posedge clock);
    rd(3'h1, v); chk("status", 8'he1, v);
    rd(3'h2, v); chk("data", 8'h3c, v);
    $display("test ninth done");
  endtask
  task t_overrun;
    setup(8'h41);
    remote.send(9'h011, 8);
    remote.send(9'h022, 8);
    remote.send(9'h033, 8);
    repeat (10) @(posedge clock);
    rd(3'h1, v); chk("status", 8'ha3, v);
    rd(3'h2, v); chk("data", 8'h11, v);
    rd(3'h1, v); chk("status", 8'ha1, v);
    rd(3'h2, v); chk("data", 8'h22, v);
    $display("test overrun done");
  endtask
  task t_break_rx;
    setup(8'h01);
    fork remote.low(16); join_none
    repeat (200) @(posedge clock);
    rd(3'h1, v); chk("status", 8'ha5, v);
    rd(3'h2, v); chk("data", 8'h00, v);
    repeat (150) @(posedge clock);
    rd(3'h1, v); chk("avail", 8'h00, v & 8'h01);
    $display("test break rx done");
  endtask
  task t_break_tx;
    setup(8'h20);
    n = 0;
    while (tx_line !== 1'b0 && n < 400) begin @(posedge clock); n++; end
    repeat (300) @(posedge clock);
    wr(3'h0, 8'h00);
    n = 302;
    while (tx_line !== 1'b1 && n < 900) begin @(posedge clock); n++; end
    chk("break bits", 8'd27, 8'((n + 8) / 16));
    repeat (20) @(posedge clock);
    chk("tx idle", 8'h01, {7'h0, tx_line});
    chk("irq", 8'h00, {7'h0, rx_irq});
    $display("test break tx done");
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    t_regs;
    t_rx8;
    t_ninth;
    t_overrun;
    t_break_rx;
    t_break_tx;
    stop_test;
  end
  // Whole run is near 1800 cycles; allow over thirty times that
  initial begin
    #600000;
    fail_count++;
    stop_test;
  end
endmodule // uart_rx_brk_bench
